// >>> rtl/hdr_record_if.sv
// Record-level HART interface of a four-channel current input module
// Host accesses one record byte per request; modem sits on the same clock
`timescale 1ns/1ps
`include "hdr_consts.svh"
module hdr_record_if import hdr_pkg::*; (
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic        rec_req,
  input  wire logic        rec_write,
  input  wire logic        rec_last,
  input  wire logic [7:0]  rec_index,
  input  wire logic [7:0]  rec_addr,
  input  wire logic [7:0]  rec_wdata,
  output logic             rec_ack,
  output logic             rec_err,
  output logic [7:0]       rec_rdata,
  input  wire logic        reparam,
  input  wire logic [31:0] init_retries,
  input  wire logic [31:0] init_preamble,
  input  wire logic [3:0]  init_hart_en,
  input  wire logic        load_supply_ok,
  input  wire logic        pv_update,
  input  wire logic [3:0]  pv_sel,
  input  wire logic [31:0] pv_value,
  input  wire logic [7:0]  pv_quality,
  input  wire logic        pv_supplied,
  output logic             cmd_valid,
  output logic [1:0]       cmd_ch,
  output logic [7:0]       cmd_len,
  output logic [7:0]       cmd_preamble,
  output logic             cmd_compact,
  output logic             cmd_shc,
  output logic             cmd_check,
  input  wire logic [1:0]  modem_rd_ch,
  input  wire logic [7:0]  modem_rd_addr,
  output logic [7:0]       modem_rd_data,
  input  wire logic [1:0]  modem_ch,
  input  wire logic        modem_start,
  input  wire logic        modem_done,
  input  wire logic [2:0]  modem_result,
  input  wire logic        modem_wr,
  input  wire logic [7:0]  modem_wr_addr,
  input  wire logic [7:0]  modem_wr_data,
  output logic [3:0]       cfg_hart_en,
  output logic [31:0]      cfg_retries,
  output logic [31:0]      cfg_preamble,
  output logic [31:0]      cfg_timeout,
  output logic [3:0]       cfg_primary
);

  // Message memories, 256 slots a channel so the index is {ch, byte}
  hdr_byte_t   req_mem  [0:1023];
  hdr_byte_t   resp_mem [0:1023];
  logic [31:0] pv_val   [0:15];
  logic [7:0]  pv_qc    [0:15];
  logic [15:0] pv_ok;
  hdr_result_t resp_st  [0:3];
  logic [3:0]  resp_shc;
  hdr_byte_t   ret_raw  [0:3];
  hdr_byte_t   stg      [0:7];
  logic [7:0]  stg_mask;
  hdr_byte_t   rq_ctl;
  hdr_byte_t   rq_pre;
  logic [1:0]  rq_mask;
  logic        sup_s1;
  logic        sup_s2;

  // Preamble value legal in settings and requests
  function automatic logic pre_ok(input hdr_byte_t v, input logic zero_ok);
    pre_ok = (v == `HDR_NOT_REL) || (zero_ok && v == 8'h00) ||
             (v >= `HDR_PRE_MIN && v <= `HDR_PRE_MAX);
  endfunction

  // Setting 255 stands for twenty preambles
  function automatic hdr_byte_t pre_map(input hdr_byte_t v);
    pre_map = (v == `HDR_NOT_REL) ? `HDR_PRE_MAX : v;
  endfunction

  // Directory contents by byte
  function automatic hdr_byte_t dir_byte(input logic [7:0] a);
    logic [7:0] n;
    n = a - 8'h09;
    case (a)
      8'h00:   dir_byte = 8'h02;
      8'h01:   dir_byte = 8'h00;
      8'h02:   dir_byte = `HDR_NOT_REL;
      8'h03:   dir_byte = 8'h01;
      8'h04:   dir_byte = 8'h04;
      8'h05:   dir_byte = 8'h01;
      8'h06:   dir_byte = `HDR_IDX_FEAT;
      8'h07:   dir_byte = `HDR_NOT_REL;
      8'h08:   dir_byte = `HDR_NOT_REL;
      8'h09, 8'h0a, 8'h0b, 8'h0c:
               dir_byte = `HDR_IDX_SET0 + n;
      default: dir_byte = `HDR_IDX_REQ0 + {n[6:0], 1'b0} - 8'h08;
    endcase
  endfunction

  // Record decode
  wire [7:0] rel_req  = rec_index - `HDR_IDX_REQ0;
  wire [7:0] rel_set  = rec_index - `HDR_IDX_SET0;
  wire       in_msg   = rec_index >= `HDR_IDX_REQ0 &&
                        rec_index <= `HDR_IDX_REQ_END;
  wire       is_req   = in_msg && !rec_index[0];
  wire       is_resp  = in_msg && rec_index[0];
  wire       is_set   = rec_index >= `HDR_IDX_SET0 &&
                        rec_index <= `HDR_IDX_SET3;
  wire       is_dir   = rec_index == `HDR_IDX_DIR;
  wire       is_feat  = rec_index == `HDR_IDX_FEAT;
  wire       is_var   = rec_index == `HDR_IDX_VAR;
  wire [1:0] msg_ch   = rel_req[2:1];
  wire [1:0] set_ch   = rel_set[1:0];
  wire [9:0] msg_at   = {msg_ch, rec_addr};
  wire [7:0] rec_len  = is_dir  ? `HDR_LEN_DIR  :
                        is_feat ? `HDR_LEN_FEAT :
                        is_var  ? `HDR_LEN_VAR  :
                        is_set  ? `HDR_LEN_SET  : `HDR_LEN_MSG;
  wire       known    = in_msg || is_set || is_dir || is_feat || is_var;
  wire       in_range = known && rec_addr < rec_len;
  wire       read_only = is_dir || is_feat || is_var || is_resp;

  // Variable record: entry is addr/5, byte within entry is the rest
  wire [15:0] div_prod = {8'h00, rec_addr} * `HDR_DIV5_MUL;
  wire [3:0]  v_ent    = div_prod[`HDR_DIV5_SHF +: 4];
  wire [7:0]  v_sub    = rec_addr - {4'h0, v_ent} * 8'h05;
  wire        v_live   = pv_ok[v_ent] && cfg_hart_en[v_ent[3:2]];
  wire [7:0]  v_shift  = {3'h0, v_sub[1:0], 3'h0};
  wire [31:0] v_word   = pv_val[v_ent] << v_shift;
  wire [7:0]  v_byte   = (v_sub == 8'h04) ?
                         (v_live ? pv_qc[v_ent] : `HDR_QC_INIT) :
                         (v_live ? v_word[31:24] : 8'h00);

  // Settings readback; bit 7 of byte 0 reads cleared after evaluation
  wire [7:0] set_byte;
  assign set_byte =
    (rec_addr == 8'h01) ? `HDR_SET_MFR :
    (rec_addr == 8'h02) ? ret_raw[set_ch] :
    (rec_addr == 8'h03) ? cfg_preamble[set_ch*8 +: 8] :
    (rec_addr == 8'h05) ? cfg_timeout[set_ch*8 +: 8] :
    (rec_addr == 8'h06) ? {6'h00, 1'b1, cfg_hart_en[set_ch]} :
    8'h00;

  // Response control: state, sequential bit, transparent format
  wire [7:0] resp_ctl = {1'b0, resp_shc[msg_ch], 3'h0, resp_st[msg_ch]};

  wire [7:0] rd_byte =
    is_dir  ? dir_byte(rec_addr) :
    is_feat ? ((rec_addr == 8'h00) ? `HDR_FEAT_B0 :
               (rec_addr == 8'h01) ? 8'h00 : `HDR_LEN_MSG) :
    is_var  ? v_byte :
    is_set  ? set_byte :
    is_req  ? req_mem[msg_at] :
    (rec_addr == 8'h00) ? resp_ctl : resp_mem[msg_at];

  // Settings record as it stands with the current byte merged in
  hdr_byte_t sv [0:7];
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      sv[i] = (rec_addr == 8'(i)) ? rec_wdata : stg[i];
    end
  end
  wire [7:0] set_mask = stg_mask | (8'h01 << rec_addr[2:0]);
  wire set_ok = set_mask == 8'hff && sup_s2 &&
                sv[0] == `HDR_SET_B0 && sv[1] == `HDR_SET_MFR &&
                sv[4] == 8'h00 && sv[7] == 8'h00 &&
                pre_ok(sv[3], 1'b1) && sv[5] != 8'h00 &&
                (sv[6] & `HDR_S6_RSVD) == 8'h00;

  // Request record checks, made on the last byte
  wire [7:0] q_ctl  = (rec_addr == 8'h00) ? rec_wdata : rq_ctl;
  wire [7:0] q_pre  = (rec_addr == 8'h01) ? rec_wdata : rq_pre;
  wire [1:0] q_mask = rq_mask | {rec_addr == 8'h01, rec_addr == 8'h00};
  wire q_busy = resp_st[msg_ch] == `HDR_ST_WAIT ||
                resp_st[msg_ch] == `HDR_ST_EXEC;
  wire req_ok = q_mask == 2'b11 && (q_ctl & `HDR_CTL_RSVD) == 8'h00 &&
                pre_ok(q_pre, 1'b0) && cfg_hart_en[msg_ch];
  wire [7:0] eff_pre = (q_pre == `HDR_NOT_REL) ?
                       pre_map(cfg_preamble[msg_ch*8 +: 8]) : q_pre;

  wire do_wr  = rec_req && rec_write;
  wire w_bad  = !in_range || read_only || (is_req && q_busy);
  wire w_set  = do_wr && !w_bad && is_set;
  wire w_req  = do_wr && !w_bad && is_req;
  wire adopt  = w_set && rec_last && set_ok;
  wire launch = w_req && rec_last && req_ok;
  wire w_fail = do_wr && (w_bad || (is_set && rec_last && !set_ok) ||
                          (is_req && rec_last && !req_ok));
  wire [7:0] ret_cl = (sv[2] > `HDR_RETRY_MAX) ? `HDR_RETRY_MAX : sv[2];

  // Load supply comes from a pin
  always_ff @(posedge ref_clk) begin
    sup_s1 <= load_supply_ok;
    sup_s2 <= sup_s1;
  end

  // Host answer, one cycle after each request
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rec_ack   <= 1'b0;
      rec_err   <= 1'b0;
      rec_rdata <= 8'h00;
    end else begin
      rec_ack   <= rec_req;
      rec_err   <= rec_req && (rec_write ? w_fail : !in_range);
      rec_rdata <= (rec_req && !rec_write && in_range) ? rd_byte : 8'h00;
    end
  end

  // Staging of a settings record; restarts once a record is evaluated
  always_ff @(posedge ref_clk) begin
    if (reset || (w_set && rec_last) || (do_wr && !is_set)) begin
      stg_mask <= 8'h00;
    end else if (w_set) begin
      stg[rec_addr[2:0]] <= rec_wdata;
      stg_mask           <= set_mask;
    end
  end

  // Request header staging and message bodies
  always_ff @(posedge ref_clk) begin
    if (reset || (w_req && rec_last) || (do_wr && !is_req)) begin
      rq_mask <= 2'b00;
    end else if (w_req) begin
      rq_ctl  <= q_ctl;
      rq_pre  <= q_pre;
      rq_mask <= q_mask;
    end
    if (w_req) begin
      req_mem[msg_at] <= rec_wdata;
    end
    if (modem_wr) begin
      resp_mem[{modem_ch, modem_wr_addr}] <= modem_wr_data;
    end
    modem_rd_data <= req_mem[{modem_rd_ch, modem_rd_addr}];
  end

  // Per-channel settings
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cfg_hart_en  <= 4'h0;
      cfg_retries  <= 32'h0;
      cfg_preamble <= 32'h0;
      cfg_timeout  <= {4{`HDR_TMO_INIT}};
      cfg_primary  <= 4'hf;
      for (int c = 0; c < 4; c++) begin
        ret_raw[c] <= 8'h00;
      end
    end else if (reparam) begin
      cfg_hart_en  <= init_hart_en;
      cfg_preamble <= init_preamble;
      cfg_timeout  <= {4{`HDR_TMO_INIT}};
      for (int c = 0; c < 4; c++) begin
        ret_raw[c] <= init_retries[c*8 +: 8];
        cfg_retries[c*8 +: 8] <= (init_retries[c*8 +: 8] > `HDR_RETRY_MAX) ?
                                 `HDR_RETRY_MAX : init_retries[c*8 +: 8];
      end
    end else if (adopt) begin
      ret_raw[set_ch]            <= sv[2];
      cfg_retries[set_ch*8 +: 8] <= ret_cl;
      cfg_preamble[set_ch*8 +: 8] <= sv[3];
      cfg_timeout[set_ch*8 +: 8] <= sv[5];
      cfg_hart_en[set_ch]        <= sv[6][0];
    end
    cfg_primary <= 4'hf;
  end

  // Command hand-off to the modem and response state
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cmd_valid    <= 1'b0;
      cmd_ch       <= 2'h0;
      cmd_len      <= 8'h00;
      cmd_preamble <= 8'h00;
      cmd_compact  <= 1'b0;
      cmd_shc      <= 1'b0;
      cmd_check    <= 1'b0;
      resp_shc     <= 4'h0;
      for (int c = 0; c < 4; c++) begin
        resp_st[c] <= `HDR_ST_IDLE;
      end
    end else begin
      cmd_valid <= launch;
      if (launch) begin
        cmd_ch           <= msg_ch;
        cmd_len          <= rec_addr + 8'h01;
        cmd_preamble     <= eff_pre;
        cmd_compact      <= q_ctl[5];
        cmd_shc          <= q_ctl[6];
        cmd_check        <= q_ctl[2];
        resp_shc[msg_ch] <= q_ctl[6];
        resp_st[msg_ch]  <= `HDR_ST_WAIT;
      end
      // The modem only reports on a channel that is already busy
      if (modem_start) begin
        resp_st[modem_ch] <= `HDR_ST_EXEC;
      end else if (modem_done) begin
        resp_st[modem_ch] <= modem_result;
      end
    end
  end

  // Process variables from the modem's cyclic polling
  always_ff @(posedge ref_clk) begin
    if (reset || reparam) begin
      pv_ok <= 16'h0000;
    end else if (pv_update) begin
      pv_val[pv_sel] <= pv_value;
      pv_qc[pv_sel]  <= pv_quality;
      pv_ok[pv_sel]  <= pv_supplied;
    end
  end

endmodule

// >>> shared/hdr_consts.svh
// Constants of the HART data record interface
// Assumes a single 100 MHz clock and byte-wide record access
// What this block does
// - Directory reads revision 2.0, one client, four channels, 255 if unused
// - Directory offset 1; response record is request record plus one
// - Directory gives feature index 149, module and burst index 255
// - Directory lists settings index 131+n and request index 80+2n
// - Feature record reads 0x62, 0, then maximum length 240
// - Four process variables collected per channel, sixteen in all, readable as record 121
// - Each entry is four value bytes then quality; twenty bytes a channel
// - Disabled channel or missing variable reads value zero, quality 0x37
// - Reparameterization restores settings from the channel parameter record
// - Without load supply written settings are refused and kept
// - Settings records 131 to 134 serve channels 0 to 3
// - Settings byte 0 must be 128; bit 7 reads cleared after evaluation
// - Retry count 0 to 255 accepted, at most ten used
// - Preamble setting 0, 5 to 20 or 255; 255 means twenty
// - Client timeout 1 to 255 seconds, sixty after reset
// - Enable from byte 6 bit 0; always primary master
// - Request records 80,82,84,86; responses 81,83,85,87
// - Bit 5 selects compact format, bit 6 sequential command mode
// - Responses are always in transparent format
// - Any invalid parameter discards the whole record
// - Response control bits 0-2 give the processing state
// - Request preamble 255 uses the channel's configured preamble
`ifndef HDR_CONSTS_SVH
`define HDR_CONSTS_SVH
`define HDR_IDX_REQ0    8'h50
`define HDR_IDX_REQ_END 8'h57
`define HDR_IDX_VAR     8'h79
`define HDR_IDX_SET0    8'h83
`define HDR_IDX_SET3    8'h86
`define HDR_IDX_DIR     8'h94
`define HDR_IDX_FEAT    8'h95
`define HDR_NOT_REL     8'hff
`define HDR_LEN_DIR     8'h11
`define HDR_LEN_FEAT    8'h03
`define HDR_LEN_VAR     8'h50
`define HDR_LEN_SET     8'h08
`define HDR_LEN_MSG     8'hf0
`define HDR_FEAT_B0     8'h62
`define HDR_QC_INIT     8'h37
`define HDR_SET_B0      8'h80
`define HDR_SET_MFR     8'h05
`define HDR_RETRY_MAX   8'h0a
`define HDR_PRE_MIN     8'h05
`define HDR_PRE_MAX     8'h14
`define HDR_TMO_INIT    8'h3c
`define HDR_CTL_RSVD    8'h9b
`define HDR_S6_RSVD     8'hfc
`define HDR_DIV5_MUL    16'h00cd
`define HDR_DIV5_SHF    10
`define HDR_ST_IDLE     3'h0
`define HDR_ST_WAIT     3'h2
`define HDR_ST_EXEC     3'h3
`endif

// >>> shared/hdr_pkg.sv
// Types shared by the HART data record interface
// Assumes the constants header is compiled alongside
package hdr_pkg;
  typedef logic [7:0] hdr_byte_t;
  typedef logic [2:0] hdr_result_t;
  typedef enum {HDR_OP_READ, HDR_OP_WRITE} hdr_op_e;
endpackage

// >>> verif/hdr_chk.sv
// Port checker for the HART record interface
// Bound to hdr_record_if; watches its ports on the one clock
`timescale 1ns/1ps
module hdr_chk (
  input wire logic        ref_clk,
  input wire logic        reset,
  input wire logic        rec_req,
  input wire logic        rec_write,
  input wire logic        rec_last,
  input wire logic [7:0]  rec_index,
  input wire logic [7:0]  rec_addr,
  input wire logic        rec_ack,
  input wire logic        rec_err,
  input wire logic [7:0]  rec_rdata,
  input wire logic        reparam,
  input wire logic [3:0]  init_hart_en,
  input wire logic        load_supply_ok,
  input wire logic [3:0]  cfg_hart_en,
  input wire logic [31:0] cfg_retries,
  input wire logic [31:0] cfg_timeout
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  // Host request shapes
  sequence s_rd(i, a);
    rec_req && !rec_write && rec_index == i && rec_addr == a;
  endsequence
  sequence s_set_last;
    rec_req && rec_write && rec_last && rec_index inside {[8'h83:8'h86]};
  endsequence
  // Supply must be seen low long enough to pass the synchroniser
  sequence s_no_supply;
    !load_supply_ok [*3];
  endsequence
  property p_dir_rev;
    s_rd(8'h94, 8'h00) |=> rec_ack && !rec_err && rec_rdata == 8'h02;
  endproperty
  a_dir_rev: assert property (p_dir_rev) else $error("dir revision");
  property p_dir_off;
    s_rd(8'h94, 8'h05) |=> rec_rdata == 8'h01;
  endproperty
  a_dir_off: assert property (p_dir_off) else $error("dir offset");
  property p_feat;
    s_rd(8'h95, 8'h00) |=> rec_rdata == 8'h62;
  endproperty
  a_feat: assert property (p_feat) else $error("feature byte");
  property p_ro_wr;
    rec_req && rec_write && rec_index inside
      {8'h94, 8'h95, 8'h79, 8'h51, 8'h53, 8'h55, 8'h57} |=> rec_err;
  endproperty
  a_ro_wr: assert property (p_ro_wr) else $error("read-only write");
  property p_var_err;
    rec_req && !rec_write && rec_index == 8'h79 && rec_addr >= 8'h50
      |=> rec_ack && rec_err;
  endproperty
  a_var_err: assert property (p_var_err) else $error("variable range");
  property p_nosup;
    s_no_supply ##0 s_set_last |=> rec_err && $stable(cfg_timeout);
  endproperty
  a_nosup: assert property (p_nosup) else $error("settings no supply");
  property p_reparam;
    reparam |=> cfg_hart_en == $past(init_hart_en) &&
      cfg_timeout == 32'h3c3c3c3c;
  endproperty
  a_reparam: assert property (p_reparam) else $error("reparam load");
  property p_clamp;
    cfg_retries[7:0] <= 8'h0a && cfg_retries[15:8] <= 8'h0a &&
      cfg_retries[23:16] <= 8'h0a && cfg_retries[31:24] <= 8'h0a;
  endproperty
  a_clamp: assert property (p_clamp) else $error("retry clamp");
endmodule

bind hdr_record_if hdr_chk u_chk (.*);

// >>> verif/hdr_modem_model.sv
// Field-side modem model serving accepted HART requests
// Same clock as the block; one request served at a time
`timescale 1ns/1ps
module hdr_modem_model (
  input  wire logic       ref_clk,
  input  wire logic       reset,
  input  wire logic       slow,
  input  wire logic       cmd_valid,
  input  wire logic [1:0] cmd_ch,
  input  wire logic [7:0] modem_rd_data,
  output logic [1:0]      modem_rd_ch,
  output logic [7:0]      modem_rd_addr,
  output logic [1:0]      modem_ch,
  output logic            modem_start,
  output logic            modem_done,
  output logic [2:0]      modem_result,
  output logic            modem_wr,
  output logic [7:0]      modem_wr_addr,
  output logic [7:0]      modem_wr_data
);
  logic [7:0] echo;
  // Slow mode leaves the request waiting long enough to be observed
  initial begin
    {modem_rd_ch, modem_rd_addr, modem_ch, modem_start} = '0;
    {modem_done, modem_result, modem_wr, modem_wr_addr} = '0;
    modem_wr_data = 8'h00;
    forever begin
      @(posedge ref_clk);
      if (cmd_valid && !reset) begin
        repeat (slow ? 40 : 2) @(posedge ref_clk);
        {modem_ch, modem_rd_ch} <= {cmd_ch, cmd_ch};
        modem_rd_addr <= 8'h02;
        modem_start <= 1'b1;
        @(posedge ref_clk);
        modem_start <= 1'b0;
        @(posedge ref_clk);
        echo = modem_rd_data;
        // Echo the first payload byte as transparent response data
        {modem_wr, modem_wr_addr, modem_wr_data} <= {1'b1, 8'h02, echo};
        @(posedge ref_clk);
        modem_wr <= 1'b0;
        modem_wr_data <= ~echo;
        {modem_done, modem_result} <= {1'b1, 3'h4};
        @(posedge ref_clk);
        {modem_done, modem_result} <= {1'b0, 3'h7};
      end
    end
  end
endmodule

// >>> verif/testbench.sv
// Self-checking bench for the HART record interface
// Drives host record accesses; a modem model answers requests
`timescale 1ns/1ps
module testbench;
  logic        ref_clk = 1'b0;
  logic        reset = 1'b1;
  logic        rec_req = 1'b0, rec_write = 1'b0, rec_last = 1'b0;
  logic [7:0]  rec_index = 8'h00, rec_addr = 8'h00, rec_wdata = 8'h00;
  logic        reparam = 1'b0, load_supply_ok = 1'b1, slow = 1'b0;
  logic [31:0] init_retries = 32'h0f030201, init_preamble = 32'h14ff0008;
  logic [3:0]  init_hart_en = 4'hb, pv_sel = 4'h5;
  logic        pv_update = 1'b0, pv_supplied = 1'b1;
  logic [31:0] pv_value = 32'h11223344;
  logic [7:0]  pv_quality = 8'h80;
  logic        rec_ack, rec_err, cmd_valid, cmd_compact, cmd_shc, cmd_check;
  logic [7:0]  rec_rdata, cmd_len, cmd_preamble, modem_rd_data;
  logic [7:0]  modem_rd_addr, modem_wr_addr, modem_wr_data;
  logic [1:0]  cmd_ch, modem_rd_ch, modem_ch;
  logic        modem_start, modem_done, modem_wr;
  logic [2:0]  modem_result;
  logic [3:0]  cfg_hart_en, cfg_primary;
  logic [31:0] cfg_retries, cfg_preamble, cfg_timeout;
  logic        g_err, g_cv;
  logic [7:0]  g_data;
  int          fail_count = 0, total_checks = 0;
  logic [7:0]  dir_tab [17] = '{8'h02, 8'h00, 8'hff, 8'h01, 8'h04, 8'h01,
    8'h95, 8'hff, 8'hff, 8'h83, 8'h84, 8'h85, 8'h86, 8'h50, 8'h52, 8'h54,
    8'h56};
  logic [7:0]  ro_tab [5] = '{8'h94, 8'h95, 8'h79, 8'h51, 8'h57};
  logic [39:0] pv_exp = 40'h1122334480;

  hdr_record_if dut (.*);
  hdr_modem_model modem (.*);

  always #5 ref_clk = ~ref_clk;

  task automatic chk(input string what, input logic [31:0] exp, got);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One byte access: drive, hold over the taking edge, sample the answer
  task automatic xfer(input logic w, input logic [7:0] i, a, d, input logic l);
    @(posedge ref_clk);
    {rec_req, rec_write, rec_last} <= {1'b1, w, l};
    {rec_index, rec_addr, rec_wdata} <= {i, a, d};
    @(posedge ref_clk);
    rec_req <= 1'b0;
    @(posedge ref_clk);
    chk("ack", 1, rec_ack);
    {g_err, g_cv, g_data} = {rec_err, cmd_valid, rec_rdata};
  endtask
  task automatic rd(input logic [7:0] i, a, e);
    xfer(1'b0, i, a, 8'h00, 1'b0);
    chk("rdata", e, g_data);
  endtask
  task automatic wr(input logic [7:0] i, a, d, input logic l, e);
    xfer(1'b1, i, a, d, l);
    chk("err", e, g_err);
  endtask
  // Whole settings record; only the flagged last byte may be refused
  task automatic wset(input logic [7:0] i, input logic [63:0] v,
                      input logic e);
    for (int k = 0; k < 8; k++) begin
      wr(i, k[7:0], v[8*k +: 8], k == 7, k == 7 && e);
    end
  endtask
  task automatic reparam_pulse;
    @(posedge ref_clk);
    reparam <= 1'b1;
    @(posedge ref_clk);
    reparam <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic pv_push(input logic s);
    @(posedge ref_clk);
    {pv_update, pv_supplied} <= {1'b1, s};
    @(posedge ref_clk);
    pv_update <= 1'b0;
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Bounded run; the sequence below needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge ref_clk);
    fail_count++;
    wrap_up;
  end

  initial begin
    repeat (8) @(posedge ref_clk);
    reset <= 1'b0;
    for (int k = 0; k < 17; k++) rd(8'h94, k[7:0], dir_tab[k]);
    rd(8'h95, 8'h00, 8'h62);
    rd(8'h95, 8'h02, 8'hf0);
    foreach (ro_tab[k]) wr(ro_tab[k], 8'h00, 8'h55, 1'b1, 1'b1);
    rd(8'h94, 8'h00, 8'h02);
    wr(8'h79, 8'h50, 8'h00, 1'b0, 1'b1);
    rd(8'h79, 8'h50, 8'h00);
    chk("var_err", 1, g_err);
    rd(8'h79, 8'h04, 8'h37);
    reparam_pulse;
    chk("retries", 32'h0a030201, cfg_retries);
    chk("en_prim", 8'hbf, {cfg_hart_en, cfg_primary});
    chk("timeout", 32'h3c3c3c3c, cfg_timeout);
    pv_push(1'b1);
    for (int k = 0; k < 5; k++) begin
      rd(8'h79, k[7:0] + 8'd25, pv_exp[39-8*k -: 8]);
    end
    pv_push(1'b0);
    rd(8'h79, 8'd25, 8'h00);
    rd(8'h79, 8'd29, 8'h37);
    wset(8'h84, 64'h00011e00080c0580, 1'b0);
    chk("set", 24'h0a081e,
        {cfg_retries[15:8], cfg_preamble[15:8], cfg_timeout[15:8]});
    rd(8'h84, 8'h00, 8'h00);
    rd(8'h84, 8'h06, 8'h03);
    wset(8'h84, 64'h00011e00030c0580, 1'b1);
    wset(8'h84, 64'h00011e00ff0c0580, 1'b0);
    chk("pre", 8'hff, cfg_preamble[15:8]);
    // Wrong maker offset and a zero timeout must both be refused
    wset(8'h84, 64'h00011e00ff0c0480, 1'b1);
    wset(8'h84, 64'h00010000ff0c0580, 1'b1);
    load_supply_ok <= 1'b0;
    wset(8'h84, 64'h00011e00140c0580, 1'b1);
    chk("pre", 8'hff, cfg_preamble[15:8]);
    load_supply_ok <= 1'b1;
    reparam_pulse;
    chk("pre_all", 32'h14ff0008, cfg_preamble);
    wr(8'h56, 8'h00, 8'h00, 1'b0, 1'b0);
    wr(8'h56, 8'h01, 8'h05, 1'b1, 1'b0);
    chk("cmd", 21'h1c0814,
        {g_cv, cmd_ch, cmd_len, cmd_preamble, cmd_compact, cmd_shc});
    repeat (20) @(posedge ref_clk);
    rd(8'h57, 8'h00, 8'h04);
    slow <= 1'b1;
    wr(8'h50, 8'h00, 8'h64, 1'b0, 1'b0);
    wr(8'h50, 8'h01, 8'hff, 1'b0, 1'b0);
    wr(8'h50, 8'h02, 8'h5a, 1'b0, 1'b0);
    wr(8'h50, 8'h03, 8'h01, 1'b1, 1'b0);
    // Request preamble 255 takes channel 0's configured eight preambles
    chk("cmd", 22'h202047,
        {g_cv, cmd_ch, cmd_len, cmd_preamble, cmd_compact, cmd_shc,
         cmd_check});
    rd(8'h51, 8'h00, 8'h42);
    wr(8'h50, 8'h01, 8'h05, 1'b1, 1'b1);
    repeat (60) @(posedge ref_clk);
    rd(8'h51, 8'h00, 8'h44);
    rd(8'h51, 8'h02, 8'h5a);
    wr(8'h50, 8'h00, 8'h01, 1'b0, 1'b0);
    wr(8'h50, 8'h01, 8'h05, 1'b1, 1'b1);
    wr(8'h54, 8'h00, 8'h00, 1'b0, 1'b0);
    wr(8'h54, 8'h01, 8'h05, 1'b1, 1'b1);
    wrap_up;
  end
endmodule
